// file: rtl/abx_pkg.sv
// Package of constants and types for the add and bit-operation execution datapath
// Overview of operation
// - Add-immediate adds an 8-bit literal to the accumulator, writes the accumulator and updates carry, nibble carry and zero.
// - Add-register sums the accumulator and the addressed data register (0 to 127) and updates carry, nibble carry and zero.
// - For byte-wide register operations, destination 0 selects the accumulator and destination 1 the data register.
// - And-immediate ANDs the accumulator with an 8-bit literal into the accumulator and updates only zero.
// - And-register ANDs accumulator and data register, routes the result by destination and updates only zero.
// - Bit-clear forces the selected bit of the data register to zero, touching no other bit and no flag.
// - Bit-set forces the selected bit of the data register to one, touching no other bit and no flag.
// - Test-skip-if-zero runs the next instruction if the bit is one, else replaces it with a no-operation.
// - Test-skip-if-one runs the next instruction if the bit is zero, else replaces it with a no-operation; no flag changes.
// - A taken skip spends a second cycle as a no-operation; an untaken skip completes in one cycle.
package abx_pkg;

  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 7;
  localparam int          BITSEL_W     = 3;
  localparam logic [7:0]  ACC_RESET    = 8'h00;
  localparam logic [2:0]  FLAGS_RESET  = 3'h0;

  typedef enum logic [3:0] {
    ABX_OP_NO_OPERATION,
    ABX_OP_ADD_IMMEDIATE_TO_ACC,
    ABX_OP_ADD_ACC_AND_REG,
    ABX_OP_AND_IMMEDIATE_WITH_ACC,
    ABX_OP_AND_ACC_WITH_REG,
    ABX_OP_REG_BIT_CLEAR,
    ABX_OP_REG_BIT_SET,
    ABX_OP_TEST_SKIP_IF_ZERO,
    ABX_OP_TEST_SKIP_IF_ONE
  } abx_op_e;

  // Decoded instruction as delivered by the decoder
  typedef struct packed {
    abx_op_e             op;
    logic                dest;
    logic [ADDR_W-1:0]   addr;
    logic [BITSEL_W-1:0] bit_sel;
    logic [DATA_W-1:0]   literal;
  } abx_instr_s;

  // Data register file write port
  typedef struct packed {
    logic                en;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } abx_regwr_s;

  // Status flags
  typedef struct packed {
    logic carry;
    logic nibble_carry_flag;
    logic zero;
  } abx_flags_s;

endpackage

// file: rtl/abx_exec.sv
// Execution datapath for add, and, bit set/clear and bit-test-skip instructions
`timescale 1ns/1ps
module abx_exec (
  input  wire logic                       sys_clk_in,
  input  wire logic                       rstn_in,
  input  wire logic                       instr_valid_in,
  input  wire abx_pkg::abx_instr_s        instr_in,
  input  wire logic [abx_pkg::DATA_W-1:0] reg_rdata_in,
  output logic [abx_pkg::ADDR_W-1:0]      reg_raddr_out,
  output abx_pkg::abx_regwr_s             reg_wr_out,
  output logic [abx_pkg::DATA_W-1:0]      acc_out,
  output abx_pkg::abx_flags_s             flags_out,
  output logic                            instr_ready_out,
  output logic                            skip_cycle_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  // Sum with carry out of bit 7 and bit 3
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, b};
    low  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    add8 = {full[8], low[4], full[7:0]};
  endfunction

  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction

  // Shared by bit-clear and bit-set so both touch exactly one bit
  function automatic logic [7:0] apply_bit(input logic [7:0] value, input logic [2:0] sel, input logic level);
    apply_bit = level ? (value | bit_mask(sel)) : (value & ~bit_mask(sel));
  endfunction

  // Immediate forms take their second operand from the instruction word
  function automatic logic uses_literal(input abx_pkg::abx_op_e op);
    uses_literal = (op == abx_pkg::ABX_OP_ADD_IMMEDIATE_TO_ACC) ||
                   (op == abx_pkg::ABX_OP_AND_IMMEDIATE_WITH_ACC);
  endfunction

  function automatic logic is_zero(input logic [7:0] value);
    is_zero = (value == 8'h00);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational execution

  logic                        busy_skip;
  logic                        exec;
  logic [abx_pkg::DATA_W-1:0]  next_result;
  logic [9:0]                  sum_w;
  logic                        tested_bit;
  logic                        write_acc;
  logic                        write_reg;
  logic                        upd_arith;
  logic                        upd_zero;
  logic                        skip_take;
  logic [abx_pkg::DATA_W-1:0]  operand_b;
  abx_pkg::abx_flags_s         next_flags;

  typedef enum logic {
    ABX_ST_RUN,
    ABX_ST_DISCARD
  } abx_state_e;

  abx_state_e                  state;
  abx_state_e                  next_state;

  // Taken skip occupies this cycle; the next instruction is discarded
  assign busy_skip       = (state == ABX_ST_DISCARD);
  assign instr_ready_out = !busy_skip;
  assign skip_cycle_out  = busy_skip;
  assign exec            = instr_valid_in && !busy_skip;
  assign reg_raddr_out   = instr_in.addr;
  assign tested_bit      = reg_rdata_in[instr_in.bit_sel];
  assign operand_b       = uses_literal(instr_in.op) ? instr_in.literal : reg_rdata_in;

  ////////////////////////////////////////////////////////////////////////////
  // Control decode: destination and flag groups per instruction

  always_comb begin
    write_acc = 1'b0;
    write_reg = 1'b0;
    upd_arith = 1'b0;
    upd_zero  = 1'b0;
    skip_take = 1'b0;
    case (instr_in.op)
      abx_pkg::ABX_OP_ADD_IMMEDIATE_TO_ACC: begin
        write_acc = 1'b1;
        upd_arith = 1'b1;
      end
      abx_pkg::ABX_OP_ADD_ACC_AND_REG: begin
        write_acc = !instr_in.dest;
        write_reg = instr_in.dest;
        upd_arith = 1'b1;
      end
      abx_pkg::ABX_OP_AND_IMMEDIATE_WITH_ACC: begin
        write_acc = 1'b1;
        upd_zero  = 1'b1;
      end
      abx_pkg::ABX_OP_AND_ACC_WITH_REG: begin
        write_acc = !instr_in.dest;
        write_reg = instr_in.dest;
        upd_zero  = 1'b1;
      end
      abx_pkg::ABX_OP_REG_BIT_CLEAR: begin
        write_reg = 1'b1;
      end
      abx_pkg::ABX_OP_REG_BIT_SET: begin
        write_reg = 1'b1;
      end
      abx_pkg::ABX_OP_TEST_SKIP_IF_ZERO: begin
        skip_take = !tested_bit;
      end
      abx_pkg::ABX_OP_TEST_SKIP_IF_ONE: begin
        skip_take = tested_bit;
      end
      // Unused codes behave as a no-operation
      default: begin
        skip_take = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result datapath

  always_comb begin
    next_result = reg_rdata_in;
    sum_w       = 10'h000;
    case (instr_in.op)
      abx_pkg::ABX_OP_ADD_IMMEDIATE_TO_ACC: begin
        sum_w       = add8(acc_out, operand_b);
        next_result = sum_w[7:0];
      end
      abx_pkg::ABX_OP_ADD_ACC_AND_REG: begin
        sum_w       = add8(acc_out, operand_b);
        next_result = sum_w[7:0];
      end
      abx_pkg::ABX_OP_AND_IMMEDIATE_WITH_ACC: begin
        next_result = acc_out & operand_b;
      end
      abx_pkg::ABX_OP_AND_ACC_WITH_REG: begin
        next_result = acc_out & operand_b;
      end
      abx_pkg::ABX_OP_REG_BIT_CLEAR: begin
        next_result = apply_bit(reg_rdata_in, instr_in.bit_sel, 1'b0);
      end
      abx_pkg::ABX_OP_REG_BIT_SET: begin
        next_result = apply_bit(reg_rdata_in, instr_in.bit_sel, 1'b1);
      end
      default: begin
        next_result = reg_rdata_in;
      end
    endcase
  end

  // Flags outside the instruction's group keep their value
  always_comb begin
    next_flags = flags_out;
    if (upd_arith) begin
      next_flags.carry             = sum_w[9];
      next_flags.nibble_carry_flag = sum_w[8];
    end
    if (upd_arith || upd_zero) begin
      next_flags.zero = is_zero(next_result);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      acc_out <= abx_pkg::ACC_RESET;
    end else if (exec && write_acc) begin
      acc_out <= next_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file write port, registered so the write lands one cycle after the instruction

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      reg_wr_out <= '0;
    end else begin
      reg_wr_out.en   <= exec && write_reg;
      reg_wr_out.addr <= instr_in.addr;
      reg_wr_out.data <= next_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; bit and test operations leave them untouched

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      flags_out <= abx_pkg::FLAGS_RESET;
    end else if (exec) begin
      flags_out <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Skip state: one no-operation cycle after a taken test

  always_comb begin
    next_state = state;
    case (state)
      ABX_ST_RUN: begin
        if (exec && skip_take) begin
          next_state = ABX_ST_DISCARD;
        end
      end
      // Exactly one discarded cycle, then back to normal issue
      ABX_ST_DISCARD: begin
        next_state = ABX_ST_RUN;
      end
      default: begin
        next_state = ABX_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state <= ABX_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

endmodule

// file: tb/abx_exec_props.sv
// Port assertions for the add and bit-operation datapath
`timescale 1ns/1ps
module abx_exec_props (
  input wire logic                sys_clk_in,
  input wire logic                rstn_in,
  input wire logic                instr_valid_in,
  input wire abx_pkg::abx_instr_s instr_in,
  input wire logic [7:0]          reg_rdata_in,
  input wire abx_pkg::abx_regwr_s reg_wr_out,
  input wire logic [7:0]          acc_out,
  input wire abx_pkg::abx_flags_s flags_out,
  input wire logic                instr_ready_out,
  input wire logic                skip_cycle_out
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  wire [3:0] op = instr_in.op;
  wire       tk = instr_valid_in && instr_ready_out;
  wire       bt = reg_rdata_in[instr_in.bit_sel];
  //////////////////////////////////////////
  skip_zero_a: assert property (tk && op == 4'h7 && !bt |=> skip_cycle_out && !instr_ready_out)
    else $error("no skip on clear bit");
  skip_one_a: assert property (tk && op == 4'h8 && bt |=> skip_cycle_out && !instr_ready_out)
    else $error("no skip on set bit");
  no_skip_a: assert property (tk && !(op == 4'h7 && !bt) && !(op == 4'h8 && bt) |=> !skip_cycle_out)
    else $error("spurious skip");
  skip_once_a: assert property (skip_cycle_out |=> !skip_cycle_out) else $error("skip too long");
  bit_flags_a: assert property (tk && op > 4'h4 |=> $stable(flags_out)) else $error("flags moved");
  and_imm_a: assert property (tk && op == 4'h3 |=> acc_out == ($past(acc_out) & $past(instr_in.literal)))
    else $error("and literal wrong");
  and_acc_a: assert property (tk && op == 4'h4 && !instr_in.dest |=>
    !reg_wr_out.en && acc_out == ($past(acc_out) & $past(reg_rdata_in))) else $error("and to acc wrong");
  add_wr_a: assert property (tk && op == 4'h2 && instr_in.dest |=>
    reg_wr_out.en && reg_wr_out.data == $past(acc_out) + $past(reg_rdata_in)) else $error("add write wrong");
  skip_c: cover property (skip_cycle_out);
  add_wr_c: cover property (tk && op == 4'h2 && instr_in.dest);
  clear_c: cover property (tk && op == 4'h5);
endmodule
bind abx_exec abx_exec_props i_props (.*);

// file: tb/abx_rf_model.sv
// Data register file model on the far side of the datapath
`timescale 1ns/1ps
module abx_rf_model (
  input  wire logic                sys_clk_in,
  input  wire logic [6:0]          raddr_in,
  input  wire abx_pkg::abx_regwr_s wr_in,
  output logic [7:0]               rdata_out
);
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
  assign rdata_out = mem[raddr_in];
  always @(posedge sys_clk_in) if (wr_in.en) mem[wr_in.addr] <= wr_in.data;
endmodule

// file: tb/test_add_and_bit_ops_exec.sv
// Self-checking bench for the add and bit-operation datapath
`timescale 1ns/1ps
module test_add_and_bit_ops_exec;
  typedef struct packed {logic [7:0] acc; abx_pkg::abx_flags_s fl; logic [8:0] wr; logic sk;} abx_note_s;
  logic                sys_clk_in = 1'b0, rstn_in = 1'b0, instr_valid_in = 1'b0;
  logic                instr_ready_out, skip_cycle_out;
  abx_pkg::abx_instr_s instr_in = '0;
  abx_pkg::abx_regwr_s reg_wr_out;
  abx_pkg::abx_flags_s flags_out, f;
  logic [7:0]          reg_rdata_in, acc_out, a, b, r, m [128];
  logic [6:0]          reg_raddr_out;
  logic [3:0]          o;
  logic [8:0]          s;
  logic [31:0]         rs = 32'h4C;
  abx_note_s           n, g, q [$];
  int                  n_fail = 0, cmp_count = 0, cyc = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  abx_exec i_dut (.*);
  abx_rf_model i_rf (.sys_clk_in, .raddr_in(reg_raddr_out), .wr_in(reg_wr_out), .rdata_out(reg_rdata_in));
  function automatic logic [31:0] xorshift(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction
  task automatic give_verdict();
    $display("fails %0d of %0d compares", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////
  // Results are registered on the taking edge itself, so each note is compared 1 ns after that edge
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc > 1500) begin
      n_fail++;
      give_verdict();
    end
    if (rstn_in && instr_valid_in && instr_ready_out) begin
      #1 g = q.pop_front();
      cmp_count++;
      if ({acc_out, flags_out, reg_wr_out.en, (reg_wr_out.en ? reg_wr_out.data : 8'h00), skip_cycle_out} !== g) begin
        n_fail++;
        $display("unexpected at %0t: result differs from %h", $time, g);
      end
    end
  end
  //////////////////////////////////////////
  initial begin
    for (int i = 0; i < 128; i++) m[i] = 8'(i * 37);
    a = abx_pkg::ACC_RESET;
    f = abx_pkg::FLAGS_RESET;
    repeat (5) @(negedge sys_clk_in);
    rstn_in = 1'b1;
    instr_valid_in = 1'b1;
    for (int i = 0; i < 400; i++) begin
      rs = xorshift(rs);
      o = rs[31:28] % 4'h9;
      instr_in = rs[22:0];
      instr_in.op = abx_pkg::abx_op_e'(o);
      // Alternate the address parity so no read meets the unforwarded write before it
      instr_in.addr[0] = i[0];
      b = (o == 4'h1 || o == 4'h3) ? instr_in.literal : m[instr_in.addr];
      s = a + b;
      r = b;
      r[instr_in.bit_sel] = o == 4'h6;
      n.wr = 9'h000;
      n.sk = 1'b0;
      case (o)
        4'h1, 4'h2: begin
          r = s[7:0];
          f = {s[8], s[4] ^ a[4] ^ b[4], r == 8'h00};
        end
        4'h3, 4'h4: begin
          r = a & b;
          f.zero = r == 8'h00;
        end
        4'h5, 4'h6: n.wr = {1'b1, r};
        4'h7, 4'h8: n.sk = b[instr_in.bit_sel] == (o == 4'h8);
        default: ;
      endcase
      if ((o == 4'h2 || o == 4'h4) && instr_in.dest) n.wr = {1'b1, r};
      else if (o inside {[4'h1:4'h4]}) a = r;
      if (n.wr[8]) m[instr_in.addr] = r;
      n.acc = a;
      n.fl = f;
      q.push_back(n);
      @(negedge sys_clk_in);
      // An add offered in the discard cycle must leave the accumulator alone
      if (n.sk) begin
        instr_in.op = abx_pkg::ABX_OP_ADD_IMMEDIATE_TO_ACC;
        instr_in.literal = rs[7:0] | 8'h01;
        @(negedge sys_clk_in);
      end
    end
    instr_valid_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    give_verdict();
  end
endmodule
